// ===== clock_div_pkg.sv
// Shared constants, field layout and lookups for the PLL branch dividers.
// Assumes one synchronous clock; every divided clock but clock_out_pin_out is a one-cycle strobe.
package clock_div_pkg;

	// System clock rate, for anyone converting strobes to time
	localparam int unsigned SYS_CLK_MHZ = 100;

	// Register byte offsets on the AXI4-Lite bus
	localparam int unsigned ADDR_W = 4;
	localparam logic [3:0] CLOCK_DIVIDER_OFFSET  = 4'h0;
	localparam logic [3:0] SECOND_DIVIDER_OFFSET = 4'h4;
	localparam logic [3:0] REF_CONTROL_OFFSET    = 4'h8;
	localparam logic [3:0] STATUS_OFFSET         = 4'hc;

	// Field positions
	localparam int unsigned POST_DIVIDE_LSB     = 6;
	localparam int unsigned PLL_ENABLE_BIT      = 5;
	localparam int unsigned GRAPHICS_SELECT_BIT = 4;
	localparam int unsigned DISPLAY_DIV_LSB     = 9;
	localparam int unsigned REF_ENABLE_BIT      = 15;
	localparam int unsigned REF_SLEEP_BIT       = 13;
	localparam int unsigned REF_SOURCE_BIT      = 12;
	localparam int unsigned REF_DIV_LSB         = 8;

	// Reset values and writable bits
	localparam logic [15:0] CLOCK_DIVIDER_RESET  = 16'h0000;
	localparam logic [15:0] SECOND_DIVIDER_RESET = 16'h0000;
	localparam logic [15:0] REF_CONTROL_RESET    = 16'h0000;
	localparam logic [15:0] CLOCK_DIVIDER_MASK   = 16'h00f0;
	localparam logic [15:0] SECOND_DIVIDER_MASK  = 16'hfe00;
	localparam logic [15:0] REF_CONTROL_MASK     = 16'hbf00;

	// Fixed division counts, in input strobes
	localparam logic [1:0] SYS_FIXED_DIV = 2'h3;
	localparam logic [1:0] USB_DIV       = 2'h2;
	localparam logic [8:0] QUARTER_STEP  = 9'h004;

	// AXI responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// Decoded configuration carried to the divider logic
	typedef struct packed {
		logic [1:0] post_divide;
		logic       graphics_select;
		logic       pll_runtime_enable;
		logic [6:0] display_code;
		logic       ref_enable;
		logic       ref_run_in_sleep;
		logic       ref_source_select;
		logic [3:0] ref_divisor;
	} clock_cfg_s;

	// Input prescaler code to divisor
	function automatic logic [3:0] prescale_divisor(input logic [2:0] code);
		logic [3:0] d;
		d = 4'h1;
		unique case (code)
			3'h6: d = 4'h8;
			3'h7: d = 4'hc;
			default: d = 4'({1'b0, code}) + 4'h1;
		endcase
		return d;
	endfunction

	// Display divisor in quarter units: 4..256
	function automatic logic [8:0] display_quarters(input logic [6:0] c);
		logic [8:0] q;
		q = 9'h004 + 9'(c);
		if (c > 7'h60)
			q = 9'h088 + ((9'(c) - 9'h061) << 2);
		else if (c > 7'h40)
			q = 9'h044 + ((9'(c) - 9'h040) << 1);
		return q;
	endfunction

endpackage

// ===== tick_divider.sv
// Strobe divider: one output strobe per div_in input strobes.
// Assumes tick_in is a one-cycle strobe synchronous to clk_in.
`timescale 1ns/1ps
`default_nettype none

module tick_divider #(
	parameter int W = 16
) (
	input  wire logic         clk_in,   // System clock
	input  wire logic         reset_in, // Synchronous reset, high
	input  wire logic         ce_in,    // Clock enable
	input  wire logic         run_in,   // Divider running
	input  wire logic         tick_in,  // Input strobe
	input  wire logic [W-1:0] div_in,   // Divisor, zero taken as one
	output logic              tick_out  // Divided strobe
);

	////////////////////////////////////////////////////////////////////////
	generate
		if (W < 2) begin : g_bad_width
			$error("tick_divider needs W of at least 2");
		end
	endgenerate

	logic [W-1:0] count;
	logic [W-1:0] div_now;

	// Divisor is only taken at a period boundary, so no runt period
	wire [W-1:0] div_eff = (div_in == '0) ? W'(1) : div_in;
	wire         at_end  = (count >= div_now - W'(1));

	// Counter and strobe
	always_ff @(posedge clk_in) begin
		if (reset_in) begin
			count    <= '0;
			div_now  <= W'(1);
			tick_out <= 1'b0;
		end else if (ce_in) begin
			if (!run_in) begin
				count    <= '0;
				div_now  <= div_eff;
				tick_out <= 1'b0;
			end else if (tick_in && at_end) begin
				count    <= '0;
				div_now  <= div_eff;
				tick_out <= 1'b1;
			end else begin
				count    <= tick_in ? count + W'(1) : count;
				tick_out <= 1'b0;
			end
		end
	end

endmodule

`default_nettype wire

// ===== pll_branch_clock_dividers.sv
// PLL branch dividers: system, USB, graphics, display and reference clocks.
// Assumes the PLL core and oscillators sit outside and deliver strobes.
`timescale 1ns/1ps
`default_nettype none

module pll_branch_clock_dividers
	import clock_div_pkg::*;
#(
	parameter int REF_DIV_W = 16
) (
	input  wire logic              sys_clk_in,      // 100 MHz clock
	input  wire logic              reset_in,        // Sync reset, high
	input  wire logic              ce_in,           // Clock enable
	// AXI4-Lite slave
	input  wire logic [ADDR_W-1:0] awaddr_in,       // Write address
	input  wire logic              awvalid_in,      // Write addr valid
	output logic                   awready_out,     // Write addr ready
	input  wire logic [31:0]       wdata_in,        // Write data
	input  wire logic [3:0]        wstrb_in,        // Byte strobes
	input  wire logic              wvalid_in,       // Write data valid
	output logic                   wready_out,      // Write data ready
	output logic [1:0]             bresp_out,       // Write response
	output logic                   bvalid_out,      // Response valid
	input  wire logic              bready_in,       // Response ready
	input  wire logic [ADDR_W-1:0] araddr_in,       // Read address
	input  wire logic              arvalid_in,      // Read addr valid
	output logic                   arready_out,     // Read addr ready
	output logic [31:0]            rdata_out,       // Read data
	output logic [1:0]             rresp_out,       // Read response
	output logic                   rvalid_out,      // Read data valid
	input  wire logic              rready_in,       // Read data ready
	// Clock sources and device state
	input  wire logic              pll_tick_in,     // 96 MHz PLL strobe
	input  wire logic              osc_tick_in,     // Primary osc strobe
	input  wire logic              pll_enable_config_bit_in, // Config
	input  wire logic [2:0]        pll_input_prescale_in,    // Config
	input  wire logic              sleep_in,        // Device asleep
	input  wire logic              primary_osc_keep_alive_in, // Keep osc
	input  wire logic              clock_out_enable_in, // Mode allows pin
	// Clock outputs
	output logic                   pll_ref_tick_out,  // 4 MHz to PLL
	output logic                   pll_enabled_out,   // PLL enable
	output logic                   sysclk_tick_out,   // System clock
	output logic                   usb_clk_tick_out,  // 48 MHz USB
	output logic                   gfx_clk_tick_out,  // Graphics logic
	output logic                   display_clk_tick_out, // Display
	output logic                   reference_clock_pin_out, // Ref pin
	output logic                   reference_clock_pin_oe_n_out, // Low on
	output logic                   clock_out_pin_out, // Half sysclk
	output logic                   primary_osc_power_out // Osc powered
);

	////////////////////////////////////////////////////////////////////////
	// Parameter check
	generate
		if (REF_DIV_W < 16) begin : g_bad_ref
			$error("REF_DIV_W must hold a divisor of 32768");
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Register file
	logic [15:0] clock_divider_register;
	logic [15:0] second_clock_divider_register;
	logic [15:0] reference_clock_output_control;

	logic              aw_held;
	logic              w_held;
	logic [ADDR_W-1:0] aw_addr;
	logic [31:0]       w_data;
	logic [3:0]        w_strb;

	// Decode of the held write
	wire        do_write = aw_held && w_held && !bvalid_out;
	wire [15:0] lane = {{8{w_strb[1]}}, {8{w_strb[0]}}};
	wire        wr_cd  = (aw_addr == CLOCK_DIVIDER_OFFSET);
	wire        wr_cd2 = (aw_addr == SECOND_DIVIDER_OFFSET);
	wire        wr_ref = (aw_addr == REF_CONTROL_OFFSET);
	wire        wr_ok  = wr_cd || wr_cd2 || wr_ref ||
	                     (aw_addr == STATUS_OFFSET);

	// Masked byte merge keeps reserved bits at zero
	wire [15:0] m_cd  = CLOCK_DIVIDER_MASK & lane;
	wire [15:0] m_cd2 = SECOND_DIVIDER_MASK & lane;
	wire [15:0] m_ref = REF_CONTROL_MASK & lane;
	wire [15:0] next_cd  = (clock_divider_register & ~m_cd) |
	                       (w_data[15:0] & m_cd);
	wire [15:0] next_cd2 = (second_clock_divider_register & ~m_cd2) |
	                       (w_data[15:0] & m_cd2);
	wire [15:0] next_ref = (reference_clock_output_control & ~m_ref) |
	                       (w_data[15:0] & m_ref);

	// Write channel: one write under way at a time
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			aw_held     <= 1'b0;
			w_held      <= 1'b0;
			aw_addr     <= '0;
			w_data      <= '0;
			w_strb      <= '0;
			awready_out <= 1'b1;
			wready_out  <= 1'b1;
			bvalid_out  <= 1'b0;
			bresp_out   <= RESP_OKAY;
		end else if (ce_in) begin
			if (awvalid_in && awready_out) begin
				aw_held     <= 1'b1;
				aw_addr     <= awaddr_in;
				awready_out <= 1'b0;
			end
			if (wvalid_in && wready_out) begin
				w_held     <= 1'b1;
				w_data     <= wdata_in;
				w_strb     <= wstrb_in;
				wready_out <= 1'b0;
			end
			if (do_write) begin
				aw_held    <= 1'b0;
				w_held     <= 1'b0;
				bvalid_out <= 1'b1;
				bresp_out  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_out && bready_in) begin
				bvalid_out  <= 1'b0;
				awready_out <= 1'b1;
				wready_out  <= 1'b1;
			end
		end
	end

	// Register storage
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			clock_divider_register         <= CLOCK_DIVIDER_RESET;
			second_clock_divider_register  <= SECOND_DIVIDER_RESET;
			reference_clock_output_control <= REF_CONTROL_RESET;
		end else if (ce_in && do_write) begin
			if (wr_cd)
				clock_divider_register <= next_cd;
			if (wr_cd2)
				second_clock_divider_register <= next_cd2;
			if (wr_ref)
				reference_clock_output_control <= next_ref;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Read channel
	logic        gfx_sel_now;
	wire  [15:0] status_word = {9'h000, sleep_in, gfx_sel_now,
	                            pll_enabled_out, 1'b0,
	                            pll_input_prescale_in};
	wire         rd_cd  = (araddr_in == CLOCK_DIVIDER_OFFSET);
	wire         rd_cd2 = (araddr_in == SECOND_DIVIDER_OFFSET);
	wire         rd_ref = (araddr_in == REF_CONTROL_OFFSET);
	wire         rd_st  = (araddr_in == STATUS_OFFSET);
	wire  [15:0] rd_word = rd_cd  ? clock_divider_register :
	                       rd_cd2 ? second_clock_divider_register :
	                       rd_ref ? reference_clock_output_control :
	                       rd_st  ? status_word : 16'h0000;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			arready_out <= 1'b1;
			rvalid_out  <= 1'b0;
			rdata_out   <= '0;
			rresp_out   <= RESP_OKAY;
		end else if (ce_in) begin
			if (arvalid_in && arready_out) begin
				arready_out <= 1'b0;
				rvalid_out  <= 1'b1;
				rdata_out   <= {16'h0000, rd_word};
				rresp_out   <= (rd_cd || rd_cd2 || rd_ref || rd_st) ?
				               RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_out && rready_in) begin
				rvalid_out  <= 1'b0;
				arready_out <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Field decode into the carrier
	clock_cfg_s cfg;
	assign cfg.post_divide =
		clock_divider_register[POST_DIVIDE_LSB +: 2];
	assign cfg.graphics_select =
		clock_divider_register[GRAPHICS_SELECT_BIT];
	assign cfg.pll_runtime_enable =
		clock_divider_register[PLL_ENABLE_BIT];
	assign cfg.display_code =
		second_clock_divider_register[DISPLAY_DIV_LSB +: 7];
	assign cfg.ref_enable =
		reference_clock_output_control[REF_ENABLE_BIT];
	assign cfg.ref_run_in_sleep =
		reference_clock_output_control[REF_SLEEP_BIT];
	assign cfg.ref_source_select =
		reference_clock_output_control[REF_SOURCE_BIT];
	assign cfg.ref_divisor =
		reference_clock_output_control[REF_DIV_LSB +: 4];

	// PLL runs from the config bit or, failing that, the runtime bit
	wire pll_on = pll_enable_config_bit_in ||
	              cfg.pll_runtime_enable;
	wire pll_tick = pll_on && pll_tick_in;

	////////////////////////////////////////////////////////////////////////
	// Input prescaler toward the PLL reference
	tick_divider #(.W(4)) u_prescale (
		.clk_in   (sys_clk_in),
		.reset_in (reset_in),
		.ce_in    (ce_in),
		.run_in   (1'b1),
		.tick_in  (osc_tick_in),
		.div_in   (prescale_divisor(pll_input_prescale_in)),
		.tick_out (pll_ref_tick_out)
	);

	////////////////////////////////////////////////////////////////////////
	// System clock: postscaler then fixed divide by three
	logic sys_post_tick;
	logic sys_tick_raw;

	// Post divide is a power of two, independent of the prescaler
	wire [3:0] post_div = 4'h1 << cfg.post_divide;

	tick_divider #(.W(4)) u_sys_post (
		.clk_in   (sys_clk_in),
		.reset_in (reset_in),
		.ce_in    (ce_in),
		.run_in   (pll_on),
		.tick_in  (pll_tick),
		.div_in   (post_div),
		.tick_out (sys_post_tick)
	);

	// Fixed third keeps the system clock at most a third of the PLL
	tick_divider #(.W(2)) u_sys_fixed (
		.clk_in   (sys_clk_in),
		.reset_in (reset_in),
		.ce_in    (ce_in),
		.run_in   (pll_on),
		.tick_in  (sys_post_tick),
		.div_in   (SYS_FIXED_DIV),
		.tick_out (sys_tick_raw)
	);

	////////////////////////////////////////////////////////////////////////
	// USB branch: only the PLL feeds it, no external path
	logic usb_tick;

	tick_divider #(.W(2)) u_usb (
		.clk_in   (sys_clk_in),
		.reset_in (reset_in),
		.ce_in    (ce_in),
		.run_in   (pll_on),
		.tick_in  (pll_tick),
		.div_in   (USB_DIV),
		.tick_out (usb_tick)
	);

	////////////////////////////////////////////////////////////////////////
	// Graphics branch select, moved only on a 48 MHz boundary or while the PLL is off
	wire gfx_branch = gfx_sel_now ? usb_tick : pll_tick;

	always_ff @(posedge sys_clk_in) begin
		if (reset_in)
			gfx_sel_now <= 1'b0;
		else if (ce_in && (usb_tick || !pll_on))
			gfx_sel_now <= cfg.graphics_select;
	end

	////////////////////////////////////////////////////////////////////////
	// Display postscaler: fractional divide in quarter steps
	logic [8:0] disp_quarters;
	logic [8:0] disp_acc;

	wire [8:0] disp_sum  = disp_acc + QUARTER_STEP;
	wire       disp_fire = gfx_branch && (disp_sum >= disp_quarters);
	wire [8:0] next_disp_acc = disp_fire ? disp_sum - disp_quarters :
	                           gfx_branch ? disp_sum : disp_acc;

	// Divisor loads on an output strobe or while the accumulator is zero, and only with PLL on
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			disp_acc      <= '0;
			disp_quarters <= QUARTER_STEP;
		end else if (ce_in) begin
			disp_acc <= pll_on ? next_disp_acc : 9'h000;
			if (pll_on && (disp_fire || disp_acc == 9'h000))
				disp_quarters <=
					display_quarters(cfg.display_code);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Reference output: base select, power-of-two divide, sleep gate
	logic ref_tick;

	// Sleep stops the system clock, so that base dies with it
	wire sys_tick  = sys_tick_raw && !sleep_in;
	wire ref_base  = cfg.ref_source_select ? osc_tick_in
	                                       : sys_tick;
	wire ref_run   = cfg.ref_enable &&
	                 !(sleep_in && !cfg.ref_run_in_sleep);
	wire [REF_DIV_W-1:0] ref_div =
		REF_DIV_W'(1) << cfg.ref_divisor;

	tick_divider #(.W(REF_DIV_W)) u_ref (
		.clk_in   (sys_clk_in),
		.reset_in (reset_in),
		.ce_in    (ce_in),
		.run_in   (ref_run),
		.tick_in  (ref_base),
		.div_in   (ref_div),
		.tick_out (ref_tick)
	);

	// Oscillator stays powered awake, or when kept for sleep use
	wire osc_keep = !sleep_in || primary_osc_keep_alive_in ||
	                (cfg.ref_run_in_sleep &&
	                 cfg.ref_source_select);

	////////////////////////////////////////////////////////////////////////
	// Output registers
	always_ff @(posedge sys_clk_in) begin
		if (reset_in) begin
			pll_enabled_out              <= 1'b0;
			sysclk_tick_out              <= 1'b0;
			usb_clk_tick_out             <= 1'b0;
			gfx_clk_tick_out             <= 1'b0;
			display_clk_tick_out         <= 1'b0;
			reference_clock_pin_out      <= 1'b0;
			reference_clock_pin_oe_n_out <= 1'b1;
			clock_out_pin_out            <= 1'b0;
			primary_osc_power_out        <= 1'b1;
		end else if (ce_in) begin
			pll_enabled_out      <= pll_on;
			sysclk_tick_out      <= sys_tick;
			usb_clk_tick_out     <= usb_tick;
			gfx_clk_tick_out     <= gfx_branch;
			display_clk_tick_out <= disp_fire;
			reference_clock_pin_out <= ref_tick && cfg.ref_enable;
			reference_clock_pin_oe_n_out <= !cfg.ref_enable;
			// Toggle per system strobe gives half the system rate
			if (!clock_out_enable_in)
				clock_out_pin_out <= 1'b0;
			else if (sys_tick)
				clock_out_pin_out <= !clock_out_pin_out;
			primary_osc_power_out <= osc_keep;
		end
	end

endmodule

`default_nettype wire

// ===== clk_src_model.sv
// Source model: PLL and primary oscillator strobes for the dividers.
// Assumes the bench clock; each strobe lasts one cycle.
`timescale 1ns/1ps
`default_nettype none
module clk_src_model #(
	parameter int PLL_P = 2, // Cycles per PLL strobe
	parameter int OSC_P = 3  // Cycles per osc strobe
) (
	input  wire logic clk_in, // Bench clock
	input  wire logic pwr_in, // Osc powered
	output logic      pll_out, // PLL strobe
	output logic      osc_out  // Osc strobe
);
	int pc = 0;
	int oc = 0;
	// Free-running phases; unpowered osc gives no strobes at all
	always_ff @(posedge clk_in) begin
		pc <= (pc + 1) % PLL_P;
		oc <= (oc + 1) % OSC_P;
	end
	assign pll_out = (pc == 0);
	assign osc_out = (oc == 0) && pwr_in;
endmodule
`default_nettype wire

// ===== pll_branch_clock_dividers_sva.sv
// Checker on the divider ports: bus answers and strobe timing.
// Assumes binding into the top module by port name.
`timescale 1ns/1ps
`default_nettype none
module pbcd_sva
	import clock_div_pkg::*;
(
	input wire logic        sys_clk_in, // Clock
	input wire logic        reset_in, // Reset
	input wire logic        awvalid_in, // AW
	input wire logic        awready_out, // AW
	input wire logic        wvalid_in, // W
	input wire logic        wready_out, // W
	input wire logic        bvalid_out, // B
	input wire logic        bready_in, // B
	input wire logic [1:0]  bresp_out, // B
	input wire logic        arvalid_in, // AR
	input wire logic        arready_out, // AR
	input wire logic        rvalid_out, // R
	input wire logic        rready_in, // R
	input wire logic [31:0] rdata_out, // R
	input wire logic        pll_tick_in, // PLL
	input wire logic        pll_enable_config_bit_in, // Config
	input wire logic        clock_out_enable_in, // Pin mode
	input wire logic        pll_enabled_out, // PLL on
	input wire logic        sysclk_tick_out, // System
	input wire logic        usb_clk_tick_out, // USB
	input wire logic        gfx_clk_tick_out, // Graphics
	input wire logic        reference_clock_pin_out, // Ref pin
	input wire logic        reference_clock_pin_oe_n_out, // Ref oe
	input wire logic        clock_out_pin_out // Clock out
);
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (reset_in);
	sequence s_wr_taken;
		awvalid_in && awready_out && wvalid_in && wready_out;
	endsequence
	sequence s_rd_taken;
		arvalid_in && arready_out;
	endsequence
	////////////////////////////////////////////////////////////////////
	// Divide-by-3 last stage bars strobes closer than three cycles
	a_sys_gap:
	assert property (sysclk_tick_out |=> !sysclk_tick_out [*2])
		else $error("system strobes too close");
	a_usb_src:
	assert property (usb_clk_tick_out |-> $past(pll_tick_in, 2))
		else $error("usb strobe without pll strobe");
	a_gfx_src:
	assert property (gfx_clk_tick_out |->
		$past(pll_tick_in) || usb_clk_tick_out)
		else $error("graphics strobe without branch strobe");
	a_pll_cfg_on:
	assert property (pll_enable_config_bit_in |=> pll_enabled_out)
		else $error("config bit did not enable pll");
	a_ref_pin_off:
	assert property (reference_clock_pin_oe_n_out &&
		$past(reference_clock_pin_oe_n_out) |-> !reference_clock_pin_out)
		else $error("reference pin strobes while disabled");
	a_clock_out_pin_idle:
	assert property (!clock_out_enable_in && !$past(clock_out_enable_in)
		|-> !clock_out_pin_out)
		else $error("clock out pin active while disabled");
	a_wr_answer:
	assert property (s_wr_taken |-> ##[1:2] bvalid_out)
		else $error("write answer late");
	a_rd_answer:
	assert property (s_rd_taken |-> ##[1:2] rvalid_out)
		else $error("read answer late");
	a_rd_hold:
	assert property (rvalid_out && !rready_in |=>
		rvalid_out && $stable(rdata_out))
		else $error("read data not held");
	a_wr_hold:
	assert property (bvalid_out && !bready_in |=> bvalid_out &&
		$stable(bresp_out))
		else $error("write response not held");
endmodule
`default_nettype wire

// ===== tb_top.sv
// Bench for the PLL branch dividers: registers, strobe rates, sleep.
// Assumes the source model and the checker file beside it.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import clock_div_pkg::*;
	logic sys_clk_in = 0, reset_in = 1, ce_in = 1;
	logic [3:0] awaddr_in = 0, araddr_in = 0, wstrb_in = 4'hf;
	logic awvalid_in = 0, wvalid_in = 0, bready_in = 0;
	logic arvalid_in = 0, rready_in = 0, sleep_in = 0;
	logic [31:0] wdata_in = 0;
	logic pll_enable_config_bit_in = 1, primary_osc_keep_alive_in = 0;
	logic clock_out_enable_in = 1, clock_out_pin_q = 0;
	logic [2:0] pll_input_prescale_in = 0;
	logic awready_out, wready_out, bvalid_out, arready_out, rvalid_out;
	logic [1:0] bresp_out, rresp_out;
	logic [31:0] rdata_out;
	logic pll_tick_in, osc_tick_in, pll_ref_tick_out, pll_enabled_out;
	logic sysclk_tick_out, usb_clk_tick_out, gfx_clk_tick_out;
	logic display_clk_tick_out, reference_clock_pin_out;
	logic reference_clock_pin_oe_n_out, clock_out_pin_out;
	logic primary_osc_power_out;
	logic [6:0] pr;
	int compares = 0, miscompares = 0, cyc = 0;
	pll_branch_clock_dividers dut_u (.*);
	clk_src_model src_u (.clk_in(sys_clk_in), .pwr_in(primary_osc_power_out),
		.pll_out(pll_tick_in), .osc_out(osc_tick_in));
	// Probe table; clock out pin compared as changes, it is a level
	assign pr = {clock_out_pin_out != clock_out_pin_q, reference_clock_pin_out,
		pll_ref_tick_out, display_clk_tick_out, gfx_clk_tick_out,
		usb_clk_tick_out, sysclk_tick_out};
	always #5 sys_clk_in = ~sys_clk_in;
	always @(posedge sys_clk_in) begin
		clock_out_pin_q <= clock_out_pin_out;
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			report_and_stop();
		end
	end
	////////////////////////////////////////////////////////////////////
	task automatic chk(input bit ok, input string m);
		compares++;
		if (!ok) begin
			miscompares++;
			$display("CHECK FAILED t=%0t %s", $time, m);
		end
	endtask
	// Bus tasks hold each channel until its own ready edge
	task automatic wr(input logic [3:0] a, input logic [31:0] d,
		input logic [1:0] r);
		@(posedge sys_clk_in);
		awaddr_in <= a;
		wdata_in <= d;
		awvalid_in <= 1;
		wvalid_in <= 1;
		// Ready raised late so the response must be held a cycle
		forever begin
			@(posedge sys_clk_in);
			if (awready_out) awvalid_in <= 0;
			if (wready_out) wvalid_in <= 0;
			if (bvalid_out && bready_in) break;
			if (bvalid_out) bready_in <= 1;
		end
		bready_in <= 0;
		chk(bresp_out === r, "write response");
	endtask
	task automatic rd(input logic [3:0] a, input logic [31:0] e,
		input logic [1:0] r);
		@(posedge sys_clk_in);
		araddr_in <= a;
		arvalid_in <= 1;
		forever begin
			@(posedge sys_clk_in);
			if (arready_out) arvalid_in <= 0;
			if (rvalid_out && rready_in) break;
			if (rvalid_out) rready_in <= 1;
		end
		rready_in <= 0;
		chk(rdata_out === e && rresp_out === r, "read data");
	endtask
	task automatic stb(input int i);
		do @(negedge sys_clk_in); while (pr[i] !== 1'b1);
	endtask
	// Skips two strobes so an old divisor runs out, then times four
	task automatic per(input int i, input int e);
		int n;
		n = 0;
		repeat (2) stb(i);
		repeat (4) do begin
			@(negedge sys_clk_in);
			n++;
		end while (pr[i] !== 1'b1);
		chk(n == e, "strobe period");
		@(posedge sys_clk_in);
	endtask
	task automatic cnt(input int i, input int c, input int e);
		int n;
		n = 0;
		repeat (c) begin
			@(negedge sys_clk_in);
			n += (pr[i] === 1'b1);
		end
		chk(n == e, "strobe count");
		@(posedge sys_clk_in);
	endtask
	////////////////////////////////////////////////////////////////////
	task automatic t_regs();
		logic [15:0] m [3] = '{16'h00f0, 16'hfe00, 16'hbf00};
		for (int i = 0; i < 3; i++) begin
			rd(4'(4 * i), 0, RESP_OKAY);
			wr(4'(4 * i), 32'hffffffff, RESP_OKAY);
			rd(4'(4 * i), {16'h0, m[i]}, RESP_OKAY);
			wr(4'(4 * i), 0, RESP_OKAY);
		end
		rd(4'hc, 32'h10, RESP_OKAY);
		wr(4'h2, 32'hffff, RESP_SLVERR);
		rd(4'h2, 0, RESP_SLVERR);
		$display("done regs");
	endtask
	task automatic t_pll();
		pll_enable_config_bit_in <= 0;
		repeat (3) @(posedge sys_clk_in);
		chk(pll_enabled_out === 1'b0, "pll off");
		wr(4'h0, 32'h20, RESP_OKAY);
		repeat (2) @(posedge sys_clk_in);
		chk(pll_enabled_out === 1'b1, "pll runtime on");
		pll_enable_config_bit_in <= 1;
		wr(4'h0, 0, RESP_OKAY);
		$display("done pll");
	endtask
	task automatic t_sys();
		// Codes 2 and 3 only with no USB consumer present
		for (int c = 0; c < 4; c++) begin
			wr(4'h0, 32'(c << 6), RESP_OKAY);
			per(0, 24 << c);
		end
		wr(4'h0, 0, RESP_OKAY);
		pll_input_prescale_in <= 3'h7;
		per(0, 24);
		pll_input_prescale_in <= 3'h0;
		per(1, 16);
		per(2, 8);
		wr(4'h0, 32'h10, RESP_OKAY);
		per(2, 16);
		wr(4'h0, 0, RESP_OKAY);
		per(6, 24);
		clock_out_enable_in <= 0;
		// Pin may fall once as it is forced low
		repeat (2) @(posedge sys_clk_in);
		cnt(6, 40, 0);
		clock_out_enable_in <= 1;
		$display("done sys");
	endtask
	task automatic t_disp();
		logic [6:0] c [6] = '{7'h00, 7'h01, 7'h40, 7'h41, 7'h61, 7'h7f};
		int q [6] = '{4, 5, 68, 70, 136, 256};
		// With the PLL off the display divider must stay silent
		pll_enable_config_bit_in <= 0;
		repeat (2) @(posedge sys_clk_in);
		cnt(3, 40, 0);
		pll_enable_config_bit_in <= 1;
		for (int i = 0; i < 6; i++) begin
			wr(4'h4, 32'(c[i]) << 9, RESP_OKAY);
			per(3, 2 * q[i]);
		end
		$display("done display");
	endtask
	task automatic t_pre();
		int d [8] = '{1, 2, 3, 4, 5, 6, 8, 12};
		for (int i = 0; i < 8; i++) begin
			pll_input_prescale_in <= 3'(i);
			per(4, 12 * d[i]);
		end
		pll_input_prescale_in <= 0;
		$display("done prescale");
	endtask
	task automatic t_ref();
		wr(4'h8, 32'h9000, RESP_OKAY);
		per(5, 12);
		wr(4'h8, 32'h9200, RESP_OKAY);
		per(5, 48);
		chk(reference_clock_pin_oe_n_out === 1'b0, "oe on");
		wr(4'h8, 32'h8100, RESP_OKAY);
		per(5, 48);
		wr(4'h8, 32'h1000, RESP_OKAY);
		cnt(5, 40, 0);
		chk(reference_clock_pin_oe_n_out === 1'b1, "oe off");
		$display("done ref");
	endtask
	task automatic t_sleep();
		wr(4'h8, 32'h9000, RESP_OKAY);
		sleep_in <= 1;
		repeat (6) @(posedge sys_clk_in);
		cnt(5, 40, 0);
		cnt(0, 40, 0);
		chk(primary_osc_power_out === 1'b0, "osc off");
		wr(4'h8, 32'hb000, RESP_OKAY);
		per(5, 12);
		chk(primary_osc_power_out === 1'b1, "osc kept");
		primary_osc_keep_alive_in <= 1;
		wr(4'h8, 32'h9000, RESP_OKAY);
		repeat (4) @(posedge sys_clk_in);
		chk(primary_osc_power_out === 1'b1, "keep alive");
		sleep_in <= 0;
		$display("done sleep");
	endtask
	task automatic report_and_stop();
		$display("compares=%0d miscompares=%0d", compares, miscompares);
		if (miscompares == 0 && compares > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	initial begin
		repeat (3) @(posedge sys_clk_in);
		reset_in <= 0;
		t_regs();
		t_pll();
		t_sys();
		t_disp();
		t_pre();
		t_ref();
		t_sleep();
		report_and_stop();
	end
endmodule
bind pll_branch_clock_dividers pbcd_sva chk_u (.*);
`default_nettype wire
